// file: common/inqr_pkg.sv
// Constants, field layouts and carrier types for the inquiry responder
package inqr_pkg;

	// ****************************************
	// Command descriptor block
	// ****************************************
	localparam int CDB_LEN = 6;
	localparam logic [7:0] OPC_INQUIRY = 8'h12;
	localparam int EVPD_BIT = 0;
	localparam int LUN_MSB = 7;
	localparam int LUN_LSB = 5;

	// ****************************************
	// Returned data layout
	// ****************************************
	localparam logic [7:0] STD_LEN = 8'h24; // 36 mandatory bytes
	localparam logic [7:0] ADD_LEN = 8'(STD_LEN - 8'h05); // Bytes after byte 4, so 31
	localparam logic [7:0] VPD_LEN = 8'h05; // Supported pages list only
	localparam logic [7:0] ID_FIRST = 8'h08;
	localparam int ID_BYTES = 28; // Vendor 8..15, product 16..31, revision 32..35
	localparam logic [7:0] NO_LUN_BYTE = 8'h7F;
	localparam logic [7:0] ASCII_SPACE = 8'h20;
	localparam logic [2:0] ANSI_VERSION = 3'h2;
	localparam logic [3:0] RESP_FORMAT = 4'h2;
	localparam logic [3:0] SENSE_ILLEGAL = 4'h5;
	localparam logic [7:0] ASC_BAD_CDB = 8'h24;

	// ****************************************
	// Register map, byte addresses
	// ****************************************
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_DEVID = 8'h04;
	localparam logic [7:0] OFS_CAPS = 8'h08;
	localparam logic [7:0] OFS_LUNS = 8'h0C;
	localparam logic [7:0] OFS_STAT = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [7:0] OFS_SENSE = 8'h18;
	localparam logic [7:0] OFS_ID = 8'h20; // 28 words, one id byte each
	localparam int CTRL_VPD = 0;
	localparam int CTRL_RMB = 1;
	localparam int CTRL_IDOK = 2;
	localparam logic [2:0] RST_CTRL = 3'h0;
	localparam logic [7:0] RST_DEVID = 8'h00;
	localparam logic [7:0] RST_CAPS = 8'h00;
	localparam logic [7:0] RST_LUNS = 8'h01;
	localparam int IRQ_DONE = 0;
	localparam int IRQ_CHECK = 1;
	localparam int IRQ_BADOP = 2;

	// ****************************************
	// Carrier types
	// ****************************************
	typedef struct packed {
		logic valid;
		logic last;
		logic [7:0] data;
	} inqr_byte_s;

	typedef struct packed {
		logic [7:0] asc;
		logic [3:0] key;
	} inqr_sense_s;

	typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_SEND, ST_DONE} inqr_state_e;

endpackage

// file: hw/inqr_responder.sv
// Inquiry command decoder and data responder with register port and interrupt
`timescale 1ns/1ps

// What this block does
// - Six CDB bytes: opcode 12h, LUN and EVPD in byte 1, page, length, control.
// - EVPD one returns vital product page 00h, the only page held, when the page code names it.
// - EVPD one without product data support ends CHECK, illegal request, bad CDB field.
// - EVPD zero returns the standard inquiry data block.
// - EVPD zero with nonzero page code ends CHECK, illegal request, bad CDB field.
// - CHECK status only when the requested data cannot be returned.
// - Pending unit attention neither blocks the command nor gets cleared.
// - Inquiry data is returned even while the peripheral is not ready.
// - Data served at once; unloaded identity fields read as ASCII spaces.
// - Returned data may change as software reloads its fields.
// - Standard block holds 36 mandatory bytes; reserved bytes go as zero.
// - Byte 0 holds qualifier in bits 7..5 and device type in 4..0.
// - Unsupported logical unit reports byte 0 as 7Fh.
// - Byte 3 response data format is two.
// - Byte 1 bit 7 is one for removable medium.
module inqr_responder (
	input wire logic sys_clk_in, // 20 MHz system clock
	input wire logic resetn_in, // Asynchronous reset, active low
	input wire logic cdb_valid_in, // CDB byte strobe
	input wire logic [7:0] cdb_byte_in, // CDB byte, byte 0 first
	input wire logic ua_pending_in, // Unit attention pending for initiator
	input wire logic unit_ready_in, // Peripheral ready for media commands
	input wire logic data_ready_in, // Receiver takes the data byte
	output logic busy_out, // Command in progress
	output inqr_pkg::inqr_byte_s data_out, // Data-in stream byte
	output logic done_out, // One-cycle completion pulse
	output logic check_out, // Completion ended with CHECK CONDITION
	output inqr_pkg::inqr_sense_s sense_out, // Sense of the last completion
	input wire logic [7:0] addr_in, // Register byte address
	input wire logic [31:0] wdata_in, // Register write data
	input wire logic wr_in, // Write strobe
	input wire logic rd_in, // Read strobe
	output logic [31:0] rdata_out, // Read data, cycle after strobe
	output logic irq_out // Level interrupt
);

	// ****************************************
	// Registers
	// ****************************************
	logic [2:0] ctrl_ff;
	logic [7:0] devid_ff;
	logic [7:0] caps_ff;
	logic [7:0] luns_ff;
	logic [2:0] stat_ff;
	logic [2:0] mask_ff;
	localparam int ID_BYTES = inqr_pkg::ID_BYTES;
	logic [7:0] id_mem [ID_BYTES];
	inqr_pkg::inqr_state_e state_ff;
	logic [7:0] cdb_ff [inqr_pkg::CDB_LEN];
	logic [2:0] cnt_ff;
	logic [7:0] idx_ff;
	logic [7:0] len_ff;
	logic evpd_ff;
	logic fail_ff;
	logic [7:0] cur_byte;
	logic [7:0] avail;
	logic [7:0] byte0;
	logic [2:0] ev_set;
	logic out_free;
	logic last_take;

	// Identity window decode, shared by the write and read paths
	function automatic logic id_hit(input logic [7:0] a);
		return a >= inqr_pkg::OFS_ID && a[1:0] == 2'b00 &&
			a < 8'(inqr_pkg::OFS_ID + 8'(4 * ID_BYTES));
	endfunction

	// One identity byte per word, so the slot is the word offset
	function automatic logic [4:0] id_slot(input logic [7:0] a);
		return 5'((a - inqr_pkg::OFS_ID) >> 2);
	endfunction

	// ****************************************
	// Command capture and decode
	// ****************************************

	// Collects six CDB bytes; bytes that come while busy are dropped
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			cnt_ff <= 3'h0;
			for (int i = 0; i < inqr_pkg::CDB_LEN; i++) begin
				cdb_ff[i] <= 8'h00;
			end
		end else if (state_ff == inqr_pkg::ST_IDLE && cdb_valid_in) begin
			cdb_ff[cnt_ff] <= cdb_byte_in;
			cnt_ff <= (cnt_ff == 3'(inqr_pkg::CDB_LEN - 1)) ? 3'h0 : cnt_ff + 3'h1;
		end
	end

	assign byte0 = luns_ff[cdb_ff[1][inqr_pkg::LUN_MSB:inqr_pkg::LUN_LSB]] ?
		devid_ff : inqr_pkg::NO_LUN_BYTE;
	assign avail = cdb_ff[1][inqr_pkg::EVPD_BIT] ? inqr_pkg::VPD_LEN : inqr_pkg::STD_LEN;
	assign out_free = !data_out.valid || data_ready_in;
	assign last_take = data_out.valid && data_out.last && data_ready_in;

	// Main sequence; unit attention and readiness are deliberately not consulted
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_ff <= inqr_pkg::ST_IDLE;
			len_ff <= 8'h00;
			evpd_ff <= 1'b0;
			fail_ff <= 1'b0;
		end else begin
			case (state_ff)
				inqr_pkg::ST_IDLE: begin
					if (cdb_valid_in && cnt_ff == 3'(inqr_pkg::CDB_LEN - 1)) begin
						state_ff <= inqr_pkg::ST_DECODE;
					end
				end
				inqr_pkg::ST_DECODE: begin
					evpd_ff <= cdb_ff[1][inqr_pkg::EVPD_BIT];
					// Only page 00h exists, so any other page cannot be returned
					fail_ff <= (cdb_ff[1][inqr_pkg::EVPD_BIT] &&
						(!ctrl_ff[inqr_pkg::CTRL_VPD] || cdb_ff[2] != 8'h00)) ||
						(!cdb_ff[1][inqr_pkg::EVPD_BIT] && cdb_ff[2] != 8'h00);
					len_ff <= (cdb_ff[4] < avail) ? cdb_ff[4] : avail;
					if (cdb_ff[0] != inqr_pkg::OPC_INQUIRY) begin
						state_ff <= inqr_pkg::ST_IDLE;
					end else begin
						state_ff <= inqr_pkg::ST_SEND;
					end
				end
				inqr_pkg::ST_SEND: begin
					if (fail_ff || len_ff == 8'h00 || last_take) begin
						state_ff <= inqr_pkg::ST_DONE;
					end
				end
				inqr_pkg::ST_DONE: begin
					state_ff <= inqr_pkg::ST_IDLE;
				end
				default: begin
					state_ff <= inqr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ****************************************
	// Data byte generation
	// ****************************************

	// Byte at the current index; identity is read live, so reloads show at once
	always_comb begin
		cur_byte = 8'h00; // Reserved bytes send as zero
		if (evpd_ff) begin
			case (idx_ff)
				8'h00: cur_byte = byte0;
				8'h03: cur_byte = 8'h01; // One page listed, page 00h itself
				default: cur_byte = 8'h00;
			endcase
		end else begin
			case (idx_ff)
				8'h00: cur_byte = byte0;
				8'h01: cur_byte = {ctrl_ff[inqr_pkg::CTRL_RMB], 7'h00};
				8'h02: cur_byte = {5'h00, inqr_pkg::ANSI_VERSION};
				8'h03: cur_byte = {4'h0, inqr_pkg::RESP_FORMAT};
				8'h04: cur_byte = inqr_pkg::ADD_LEN;
				8'h07: cur_byte = {caps_ff[7:3], 1'b0, caps_ff[1:0]};
				default: begin
					if (idx_ff >= inqr_pkg::ID_FIRST && idx_ff < inqr_pkg::STD_LEN) begin
						// Spaces until software marks identity loaded
						cur_byte = ctrl_ff[inqr_pkg::CTRL_IDOK] ?
							id_mem[5'(idx_ff - inqr_pkg::ID_FIRST)] : inqr_pkg::ASCII_SPACE;
					end
				end
			endcase
		end
	end

	// Output stage advances when it is empty or the receiver takes a byte
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			data_out <= '0;
			idx_ff <= 8'h00;
		end else if (state_ff != inqr_pkg::ST_SEND || fail_ff) begin
			data_out <= '0;
			idx_ff <= 8'h00;
		end else if (out_free) begin
			if (idx_ff < len_ff) begin
				data_out.valid <= 1'b1;
				data_out.data <= cur_byte;
				data_out.last <= (idx_ff + 8'h01 == len_ff);
				idx_ff <= idx_ff + 8'h01;
			end else begin
				data_out <= '0;
			end
		end
	end

	// Completion status; sense kept until the next completion
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			done_out <= 1'b0;
			check_out <= 1'b0;
			sense_out <= '0;
			busy_out <= 1'b0;
		end else begin
			busy_out <= (state_ff == inqr_pkg::ST_DECODE) || (state_ff == inqr_pkg::ST_SEND);
			done_out <= (state_ff == inqr_pkg::ST_DONE);
			if (state_ff == inqr_pkg::ST_DONE) begin
				check_out <= fail_ff;
				sense_out.key <= fail_ff ? inqr_pkg::SENSE_ILLEGAL : 4'h0;
				sense_out.asc <= fail_ff ? inqr_pkg::ASC_BAD_CDB : 8'h00;
			end
		end
	end

	// ****************************************
	// Register port and interrupt
	// ****************************************
	assign ev_set[inqr_pkg::IRQ_DONE] = (state_ff == inqr_pkg::ST_DONE);
	assign ev_set[inqr_pkg::IRQ_CHECK] = (state_ff == inqr_pkg::ST_DONE) && fail_ff;
	assign ev_set[inqr_pkg::IRQ_BADOP] = (state_ff == inqr_pkg::ST_DECODE) &&
		(cdb_ff[0] != inqr_pkg::OPC_INQUIRY);

	// Configuration writes; identity bytes may be rewritten any time
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			ctrl_ff <= inqr_pkg::RST_CTRL;
			devid_ff <= inqr_pkg::RST_DEVID;
			caps_ff <= inqr_pkg::RST_CAPS;
			luns_ff <= inqr_pkg::RST_LUNS;
			mask_ff <= 3'h0;
			for (int i = 0; i < ID_BYTES; i++) begin
				id_mem[i] <= inqr_pkg::ASCII_SPACE;
			end
		end else if (wr_in) begin
			case (addr_in)
				inqr_pkg::OFS_CTRL: ctrl_ff <= wdata_in[2:0];
				inqr_pkg::OFS_DEVID: devid_ff <= wdata_in[7:0];
				inqr_pkg::OFS_CAPS: caps_ff <= wdata_in[7:0];
				inqr_pkg::OFS_LUNS: luns_ff <= wdata_in[7:0];
				inqr_pkg::OFS_MASK: mask_ff <= wdata_in[2:0];
				default: begin
					if (id_hit(addr_in)) begin
						id_mem[id_slot(addr_in)] <= wdata_in[7:0];
					end
				end
			endcase
		end
	end

	// Sticky events, write one to clear; a same-cycle event wins
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			stat_ff <= 3'h0;
			irq_out <= 1'b0;
		end else begin
			stat_ff <= (stat_ff & ~((wr_in && addr_in == inqr_pkg::OFS_STAT) ?
				wdata_in[2:0] : 3'h0)) | ev_set;
			irq_out <= |(stat_ff & mask_ff);
		end
	end

	// Read data; unmapped addresses return zero
	always_ff @(posedge sys_clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rdata_out <= 32'h0000_0000;
		end else if (rd_in) begin
			case (addr_in)
				inqr_pkg::OFS_CTRL: rdata_out <= {29'h0, ctrl_ff};
				inqr_pkg::OFS_DEVID: rdata_out <= {24'h0, devid_ff};
				inqr_pkg::OFS_CAPS: rdata_out <= {24'h0, caps_ff};
				inqr_pkg::OFS_LUNS: rdata_out <= {24'h0, luns_ff};
				inqr_pkg::OFS_STAT: rdata_out <= {29'h0, stat_ff};
				inqr_pkg::OFS_MASK: rdata_out <= {29'h0, mask_ff};
				inqr_pkg::OFS_SENSE: rdata_out <= {20'h0, sense_out};
				default: begin
					if (id_hit(addr_in)) begin
						rdata_out <= {24'h0, id_mem[id_slot(addr_in)]};
					end else begin
						rdata_out <= 32'h0000_0000;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_decode_std_badpage;
		state_ff == inqr_pkg::ST_DECODE && cdb_ff[0] == inqr_pkg::OPC_INQUIRY &&
			!cdb_ff[1][0] && cdb_ff[2] != 8'h00;
	endsequence

	sequence s_fail_end;
		##[2:3] done_out && check_out;
	endsequence

	// Rejected commands complete two or three cycles after decode
	a_badpage_check: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		s_decode_std_badpage |-> s_fail_end) else $error("bad page not rejected");
	a_novpd_check: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		(state_ff == inqr_pkg::ST_DECODE && cdb_ff[0] == inqr_pkg::OPC_INQUIRY &&
		cdb_ff[1][0] && !ctrl_ff[0]) |-> s_fail_end) else $error("evpd not rejected");
	a_sense_value: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		(done_out && check_out) |-> sense_out.key == 4'h5 && sense_out.asc == 8'h24)
		else $error("wrong sense");
	a_no_data_fail: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		(done_out && check_out) |-> $past(!data_out.valid, 1))
		else $error("data sent on check");
	a_alloc_bound: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		data_out.valid |-> idx_ff <= len_ff && len_ff <= cdb_ff[4])
		else $error("allocation overrun");
	// Stream checks: while byte k stands, the index already points at k+1
	a_addlen_byte: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		(data_out.valid && !evpd_ff && idx_ff == 8'h05) |-> data_out.data == 8'h1F)
		else $error("additional length");
	a_format_byte: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		(data_out.valid && !evpd_ff && idx_ff == 8'h04) |-> data_out.data[3:0] == 4'h2)
		else $error("response format");
	a_nolun_byte: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		(data_out.valid && idx_ff == 8'h01 && !luns_ff[cdb_ff[1][7:5]])
		|-> data_out.data == 8'h7F) else $error("no lun byte");
	a_hold_stall: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		(data_out.valid && !data_ready_in) |=> $stable(data_out))
		else $error("byte changed stalled");
	// Unit attention or a unit that is not ready must never hold an inquiry back
	a_ua_ignored: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		(state_ff == inqr_pkg::ST_DECODE && cdb_ff[0] == inqr_pkg::OPC_INQUIRY &&
		(ua_pending_in || !unit_ready_in)) |=> state_ff == inqr_pkg::ST_SEND)
		else $error("inquiry blocked");
	a_irq_level: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
		##1 irq_out == |($past(stat_ff) & $past(mask_ff))) else $error("irq level");

endmodule

// file: verification/inqr_initiator.sv
// Initiator model: sends command blocks and takes the returned data stream
`timescale 1ns/1ps
module inqr_initiator (
	input wire logic clk_in, // System clock
	input wire logic resetn_in, // Reset, active low
	input wire logic stall_in, // Receiver stalls every other cycle
	input wire inqr_pkg::inqr_byte_s data_in, // Data stream from the target
	output logic cdb_valid_out, // Command byte strobe
	output logic [7:0] cdb_byte_out, // Command byte
	output logic data_ready_out // Receiver takes the byte
);
	logic [7:0] rx_q[$];
	logic phase_ff;

	// ****
	// Receiver
	// ****
	// Toggling phase gives a slow receiver without any random source
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			phase_ff <= 1'b0;
		end else begin
			phase_ff <= ~phase_ff;
		end
	end
	assign data_ready_out = !stall_in || phase_ff;

	// Byte is taken only on an edge with valid and ready both high
	always @(posedge clk_in) begin
		if (data_in.valid && data_ready_out) begin
			rx_q.push_back(data_in.data);
		end
	end

	// ****
	// Command sender
	// ****
	// Six bytes back to back, then the line shows no stale value
	task automatic send(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] pg,
		input logic [7:0] len);
		logic [7:0] cdb [6];
		cdb = '{b0, b1, pg, 8'h00, len, 8'h00};
		rx_q.delete();
		for (int i = 0; i < 6; i++) begin
			@(posedge clk_in);
			cdb_valid_out <= 1'b1;
			cdb_byte_out <= cdb[i];
		end
		@(posedge clk_in);
		cdb_valid_out <= 1'b0;
		cdb_byte_out <= ~cdb[5];
	endtask

	initial begin
		cdb_valid_out = 1'b0;
		cdb_byte_out = 8'h00;
	end
endmodule

// file: verification/tb_top.sv
// Self-checking testbench for the inquiry responder
`timescale 1ns/1ps
module tb_top;
	logic sys_clk_in, resetn_in, cdb_valid_in, ua_pending_in, unit_ready_in, data_ready_in;
	logic [7:0] cdb_byte_in, addr_in;
	logic [31:0] wdata_in, rdata_out;
	logic wr_in, rd_in, busy_out, done_out, check_out, irq_out, stall;
	inqr_pkg::inqr_byte_s data_out;
	inqr_pkg::inqr_sense_s sense_out;
	int err_count, n_compared;

	inqr_responder i_inqr_responder (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
		.cdb_valid_in(cdb_valid_in), .cdb_byte_in(cdb_byte_in), .ua_pending_in(ua_pending_in),
		.unit_ready_in(unit_ready_in), .data_ready_in(data_ready_in), .busy_out(busy_out),
		.data_out(data_out), .done_out(done_out), .check_out(check_out), .sense_out(sense_out),
		.addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .irq_out(irq_out));
	inqr_initiator i_inqr_initiator (.clk_in(sys_clk_in), .resetn_in(resetn_in),
		.stall_in(stall), .data_in(data_out), .cdb_valid_out(cdb_valid_in),
		.cdb_byte_out(cdb_byte_in), .data_ready_out(data_ready_in));

	// ****
	// Helpers
	// ****
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		n_compared++;
		if (got !== exp) begin
			$display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
			err_count++;
		end
	endtask

	task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk_in);
		wr_in <= 1'b1;
		addr_in <= a;
		wdata_in <= d;
		@(posedge sys_clk_in);
		wr_in <= 1'b0;
	endtask

	// Read data stand from the cycle after the strobe until the next read
	task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string m);
		@(posedge sys_clk_in);
		rd_in <= 1'b1;
		addr_in <= a;
		@(posedge sys_clk_in);
		rd_in <= 1'b0;
		#1;
		chk(rdata_out, exp, m);
	endtask

	// Inquiry with given byte 1, page and length; waits for the completion pulse
	task automatic run(input logic [7:0] b1, input logic [7:0] pg, input logic [7:0] len,
		input logic ck, input int n_exp);
		int n;
		i_inqr_initiator.send(inqr_pkg::OPC_INQUIRY, b1, pg, len);
		n = 0;
		do begin
			@(posedge sys_clk_in);
			#1;
			n++;
			if (n == 1) begin
				chk(32'(busy_out), 32'h1, "busy after command");
			end
		end while (done_out !== 1'b1 && n < 300);
		chk(32'(n < 300), 1, "no completion");
		chk(32'(busy_out), 32'h0, "idle at completion");
		chk(32'(check_out), 32'(ck), "check status");
		chk(32'(sense_out), ck ? 32'h245 : 32'h0, "sense");
		chk(i_inqr_initiator.rx_q.size(), n_exp, "byte count");
	endtask

	function automatic logic [7:0] rx(input int i);
		return i_inqr_initiator.rx_q[i];
	endfunction

	// ****
	// Scenarios
	// ****
	task automatic t_std();
		reg_rd(inqr_pkg::OFS_LUNS, 32'h1, "luns reset");
		reg_rd(8'hFC, 32'h0, "unmapped read");
		reg_wr(inqr_pkg::OFS_DEVID, 32'h03);
		reg_wr(inqr_pkg::OFS_CAPS, 32'hFF);
		reg_wr(inqr_pkg::OFS_CTRL, 32'h2);
		reg_wr(inqr_pkg::OFS_MASK, 32'h1);
		stall <= 1'b1;
		ua_pending_in <= 1'b1;
		unit_ready_in <= 1'b0;
		run(8'h00, 8'h00, 8'h28, 1'b0, 36);
		chk(rx(0), 8'h03, "qualifier and type");
		chk(rx(1), 8'h80, "removable flag");
		chk(rx(2), 8'h02, "version byte");
		chk(rx(3), 8'h02, "data format");
		chk(rx(4), 8'h1F, "additional length");
		chk({rx(5), rx(6)}, 16'h0, "reserved bytes");
		chk(rx(7), 8'hFB, "capability flags");
		for (int i = 8; i < 36; i++) begin
			chk(rx(i), 8'h20, "unloaded identity");
		end
		repeat (3) @(posedge sys_clk_in);
		chk(32'(irq_out), 1, "irq on done");
		reg_wr(inqr_pkg::OFS_STAT, 32'h7);
		repeat (3) @(posedge sys_clk_in);
		chk(32'(irq_out), 0, "irq after clear");
		stall <= 1'b0;
		ua_pending_in <= 1'b0;
		unit_ready_in <= 1'b1;
	endtask

	task automatic t_len();
		reg_wr(inqr_pkg::OFS_ID, 32'h41);
		reg_wr(inqr_pkg::OFS_CTRL, 32'h4);
		run(8'h00, 8'h00, 8'h09, 1'b0, 9);
		chk(rx(8), 8'h41, "loaded identity");
		run(8'h00, 8'h00, 8'h02, 1'b0, 2);
		run(8'h00, 8'h00, 8'h00, 1'b0, 0);
		run(8'h20, 8'h00, 8'h01, 1'b0, 1);
		chk(rx(0), inqr_pkg::NO_LUN_BYTE, "absent unit");
	endtask

	task automatic t_vpd();
		run(8'h01, 8'h00, 8'h28, 1'b1, 0);
		run(8'h00, 8'h05, 8'h28, 1'b1, 0);
		reg_wr(inqr_pkg::OFS_CTRL, 32'h1);
		run(8'h01, 8'h00, 8'h28, 1'b0, 5);
		chk(rx(0), 8'h03, "page list first byte");
		chk({rx(1), rx(2), rx(3), rx(4)}, 32'h0000_0100, "page list");
		run(8'h01, 8'h01, 8'h28, 1'b1, 0);
	endtask

	task automatic t_badop();
		int seen;
		seen = 0;
		// Earlier completions left done and check set; clear them so only the new bit shows
		reg_wr(inqr_pkg::OFS_STAT, 32'h7);
		i_inqr_initiator.send(8'h03, 8'h00, 8'h00, 8'h24);
		repeat (10) begin
			@(posedge sys_clk_in);
			#1;
			seen += int'(done_out === 1'b1);
		end
		chk(seen, 0, "foreign opcode completes");
		reg_rd(inqr_pkg::OFS_STAT, 32'h4, "foreign opcode status");
	endtask

	task automatic close_out();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// ****
	// Clock, reset, sequence
	// ****
	initial begin
		sys_clk_in = 1'b0;
		forever #25 sys_clk_in = ~sys_clk_in;
	end

	initial begin
		{resetn_in, ua_pending_in, wr_in, rd_in, stall} = '0;
		{addr_in, wdata_in} = '0;
		unit_ready_in = 1'b1;
		err_count = 0;
		n_compared = 0;
		repeat (2) @(posedge sys_clk_in);
		resetn_in <= 1'b1;
		t_std();
		t_len();
		t_vpd();
		t_badop();
		close_out();
	end

	// Whole run is a few hundred cycles; far beyond that means a hang
	initial begin
		#(50 * 20000);
		err_count++;
		close_out();
	end
endmodule
